// [shared/fdpin_pkg.sv]
package fdpin_pkg;
  // configuration byte layout
  localparam logic [7:0] FDPIN_CFG_F0_INDEX = 8'hF0;
  localparam int FDPIN_PULLUP_DIS_BIT = 7;
  localparam logic [7:0] FDPIN_CFG_F0_RESET = 8'h00;
  // timing
  localparam int FDPIN_CLK_NS = 10;
  localparam int FDPIN_STEP_PULSE_NS = 1000;
  localparam int FDPIN_STEP_PULSE_CYC =
    (FDPIN_STEP_PULSE_NS + FDPIN_CLK_NS - 1) / FDPIN_CLK_NS;
  localparam int FDPIN_WR_PULSE_NS = 100;
  localparam int FDPIN_WR_PULSE_CYC =
    (FDPIN_WR_PULSE_NS + FDPIN_CLK_NS - 1) / FDPIN_CLK_NS;
  localparam int FDPIN_CNT_W = 16;
  // density code width
  localparam int FDPIN_DEN_W = 2;
  typedef enum logic [1:0] {FDPIN_IDLE, FDPIN_PULSE} fdpin_pulse_t;
endpackage

// [logic/fdpin_pulse_gen.sv]
`timescale 1ns/10ps
// one-shot active-low open-drain pulse of fixed width
module fdpin_pulse_gen
  import fdpin_pkg::*;
#(
  parameter int WIDTH_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic fire,
  output logic busy,
  output logic pin_oe
);
  fdpin_pulse_t state_r;
  fdpin_pulse_t state_nxt;
  logic [FDPIN_CNT_W-1:0] cnt_r;
  logic [FDPIN_CNT_W-1:0] cnt_nxt;
  wire logic done = (cnt_r == FDPIN_CNT_W'(WIDTH_CYC - 1));

  // requests while busy are ignored; caller watches busy
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      FDPIN_IDLE: begin
        cnt_nxt = '0;
        if (fire) begin
          state_nxt = FDPIN_PULSE;
        end
      end
      FDPIN_PULSE: begin
        cnt_nxt = cnt_r + FDPIN_CNT_W'(1);
        if (done) begin
          state_nxt = FDPIN_IDLE;
        end
      end
      default: state_nxt = FDPIN_IDLE;
    endcase
  end

  // busy kept in a flop so the top can export it without a decode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= FDPIN_IDLE;
      cnt_r <= '0;
      pin_oe <= 1'b0;
      busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pin_oe <= (state_nxt == FDPIN_PULSE);
      busy <= (state_nxt != FDPIN_IDLE);
    end
  end
endmodule

// [logic/fdpin_top.sv]
`timescale 1ns/10ps
// Function
// - direction pin high for outward stepping, low for inward.
// - one active-low step pulse per requested single-track move.
// - side select high picks side 0, low picks side 1.
// - motor A pulled low turns drive 0 motor on, released otherwise.
// - motor B pulled low turns drive 1 motor on, released otherwise.
// - select A low selects drive A, high when not addressed.
// - select B low selects drive B, high when not addressed.
// - config bit 7 at index F0 disables input pull-ups.
// - write data goes out uncompensated as active-low pulses.
// - density select pin carries density code bit 0.
module fdpin_top
  import fdpin_pkg::*;
#(
  parameter int STEP_CYC = FDPIN_STEP_PULSE_CYC,
  parameter int WR_CYC = FDPIN_WR_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic motor_a_req,
  input wire logic motor_b_req,
  input wire logic sel_a_req,
  input wire logic sel_b_req,
  input wire logic step_req,
  input wire logic step_outward,
  input wire logic side1_req,
  input wire logic [FDPIN_DEN_W-1:0] density_code,
  input wire logic write_active,
  input wire logic write_bit,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic index_n,
  input wire logic track_zero_n,
  input wire logic write_prot_n,
  input wire logic read_data_n,
  input wire logic media_changed_n,
  output logic motor_a_on_oe,
  output logic motor_b_on_oe,
  output logic select_a_oe,
  output logic select_b_oe,
  output logic step_dir_oe,
  output logic step_oe,
  output logic side_sel_oe,
  output logic density_select_bit0_oe,
  output logic wr_serial_oe,
  output logic wr_gate_oe,
  output logic step_busy,
  output logic input_pullup_disable,
  output logic index_seen,
  output logic track_zero,
  output logic write_prot,
  output logic read_pulse,
  output logic media_changed
);
  // open-drain pins: oe high drives the pin low, oe low releases it high
  logic [7:0] cfg_f0_r;
  logic st_index_r;
  logic st_trk0_r;
  logic st_wp_r;
  logic st_rd_r;
  logic st_chg_r;
  logic rd_prev_r;
  logic motor_a_r;
  logic motor_b_r;
  logic sel_a_r;
  logic sel_b_r;
  logic dir_r;
  logic side_r;
  logic den_r;
  logic gate_r;
  logic step_fire_busy;
  logic wr_fire_busy;
  logic step_pin;
  logic wr_pin;

  // config byte decode
  wire logic cfg_hit = cfg_wr && (cfg_index == FDPIN_CFG_F0_INDEX);
  // the gate drops on the clock after protect asserts, not one write later
  wire logic gate_nxt = write_active && write_prot_n;
  wire logic wr_fire = gate_nxt && write_bit && !wr_fire_busy;
  // direction must stay put during the pulse, so step requests are ignored while busy
  wire logic step_fire = step_req && !step_fire_busy;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_f0_r <= FDPIN_CFG_F0_RESET;
    end else if (cfg_hit) begin
      cfg_f0_r <= cfg_wdata;
    end
  end

  // pin drivers, all released at reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      motor_a_r <= 1'b0;
      motor_b_r <= 1'b0;
      sel_a_r <= 1'b0;
      sel_b_r <= 1'b0;
      dir_r <= 1'b0;
      side_r <= 1'b0;
      den_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      motor_a_r <= motor_a_req;
      motor_b_r <= motor_b_req;
      sel_a_r <= sel_a_req;
      sel_b_r <= sel_b_req;
      if (step_fire) begin
        dir_r <= !step_outward;
      end
      side_r <= side1_req;
      den_r <= !density_code[0];
      gate_r <= gate_nxt;
    end
  end

  // status inputs registered, active low turned to active high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_index_r <= 1'b0;
      st_trk0_r <= 1'b0;
      st_wp_r <= 1'b0;
      st_rd_r <= 1'b0;
      st_chg_r <= 1'b0;
      rd_prev_r <= 1'b1;
    end else begin
      st_index_r <= !index_n;
      st_trk0_r <= !track_zero_n;
      st_wp_r <= !write_prot_n;
      rd_prev_r <= read_data_n;
      st_rd_r <= rd_prev_r && !read_data_n;
      st_chg_r <= !media_changed_n;
    end
  end

  fdpin_pulse_gen #(
    .WIDTH_CYC(STEP_CYC)
  ) u_step (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fire(step_fire),
    .busy(step_fire_busy),
    .pin_oe(step_pin)
  );

  fdpin_pulse_gen #(
    .WIDTH_CYC(WR_CYC)
  ) u_wdata (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .fire(wr_fire),
    .busy(wr_fire_busy),
    .pin_oe(wr_pin)
  );

  assign motor_a_on_oe = motor_a_r;
  assign motor_b_on_oe = motor_b_r;
  assign select_a_oe = sel_a_r;
  assign select_b_oe = sel_b_r;
  assign step_dir_oe = dir_r;
  assign step_oe = step_pin;
  assign side_sel_oe = side_r;
  assign density_select_bit0_oe = den_r;
  assign wr_serial_oe = wr_pin;
  assign wr_gate_oe = gate_r;
  assign step_busy = step_fire_busy;
  assign input_pullup_disable = cfg_f0_r[FDPIN_PULLUP_DIS_BIT];
  assign index_seen = st_index_r;
  assign track_zero = st_trk0_r;
  assign write_prot = st_wp_r;
  assign read_pulse = st_rd_r;
  assign media_changed = st_chg_r;

  // checks
  AST_DIR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    step_fire |=> (step_dir_oe == !$past(step_outward)))
    else $error("direction wrong for step");
  AST_STEP_W: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(step_oe) |-> step_oe [*2])
    else $error("step pulse too short");
  AST_STEP_ONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    step_fire |=> step_oe)
    else $error("step request gave no pulse");
  AST_SIDE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    side1_req |=> side_sel_oe)
    else $error("side select wrong");
  AST_MOTA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> (motor_a_on_oe == $past(motor_a_req)))
    else $error("motor a mismatch");
  AST_MOTB: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !motor_b_req |=> !motor_b_on_oe)
    else $error("motor b not released");
  AST_SELA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sel_a_req |=> select_a_oe)
    else $error("select a not driven");
  AST_SELB: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !sel_b_req |=> !select_b_oe)
    else $error("select b not released");
  AST_PULLUP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg_hit |=> (input_pullup_disable == $past(cfg_wdata[FDPIN_PULLUP_DIS_BIT])))
    else $error("pull-up disable not stored");
  AST_WDATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_serial_oe |-> (wr_gate_oe || $past(wr_gate_oe, 1) || $past(wr_serial_oe)))
    else $error("write data outside gate");
  AST_DEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(rst_b) |-> (density_select_bit0_oe == !$past(density_code[0])))
    else $error("density bit wrong");
  AST_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !write_prot_n |=> !wr_gate_oe)
    else $error("write gate while protected");
  AST_RELEASE: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> !(motor_a_on_oe || select_a_oe || wr_gate_oe || step_oe))
    else $error("pins driven after reset");
  COV_STEP: cover property (@(posedge clk_sys) disable iff (!rst_b) step_fire ##1 step_oe);
  COV_WRITE: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_gate_oe && wr_serial_oe);
  COV_PROT: cover property (@(posedge clk_sys) disable iff (!rst_b) write_active && write_prot);
  COV_CFG: cover property (@(posedge clk_sys) disable iff (!rst_b) cfg_hit);
endmodule

// [testbench/fdpin_drive_model.sv]
`timescale 1ns/10ps
// behavioural drive: head position, spinning disk, media state
module fdpin_drive_model #(
  parameter int REV_CYC = 40
) (
  input wire logic clk_sys,
  input wire logic step_pin,
  input wire logic dir_pin,
  input wire logic prot,
  input wire logic inserted,
  output logic index_n,
  output logic track_zero_n,
  output logic write_prot_n,
  output logic read_data_n,
  output logic media_changed_n,
  output int track
);
  int rev = 0;
  logic step_d = 1'b1;
  initial track = 2;
  // head moves on each falling step edge; pin high heads outward, stops at 0
  always @(posedge clk_sys) begin
    step_d <= step_pin;
    if (step_d && !step_pin) track <= dir_pin ? (track > 0 ? track - 1 : 0) : track + 1;
    rev <= (rev == REV_CYC - 1) ? 0 : rev + 1;
  end
  // status lines, all active low
  assign index_n = !(rev < 2);
  assign track_zero_n = !(track == 0);
  assign write_prot_n = !prot;
  assign media_changed_n = inserted;
  assign read_data_n = !(rev % 8 == 5);
endmodule

// [testbench/floppy_drive_pin_interface_test.sv]
`timescale 1ns/10ps
module floppy_drive_pin_interface_test;
  import fdpin_pkg::*;
  localparam int STEP = 3;
  localparam int WR = 2;
  logic clk_sys, rst_b, motor_a_req, motor_b_req, sel_a_req, sel_b_req, step_req;
  logic step_outward, side1_req, write_active, write_bit, cfg_wr, prot, inserted;
  logic [FDPIN_DEN_W-1:0] density_code;
  logic [7:0] cfg_index, cfg_wdata;
  logic index_n, track_zero_n, write_prot_n, read_data_n, media_changed_n;
  logic motor_a_on_oe, motor_b_on_oe, select_a_oe, select_b_oe, step_dir_oe, step_oe;
  logic side_sel_oe, density_select_bit0_oe, wr_serial_oe, wr_gate_oe, step_busy;
  logic input_pullup_disable, index_seen, track_zero, write_prot, read_pulse, media_changed;
  int track, checked = 0, miscompares = 0, cyc = 0;
  int st_n, st_hi, wr_n, wr_hi, idx_n, rd_n;
  logic st_q = 0, wr_q = 0;
  logic [6:0] rin [6] = '{7'h40, 7'h21, 7'h12, 7'h0B, 7'h04, 7'h7D};
  logic [5:0] rexp [6] = '{6'h21, 6'h10, 6'h09, 6'h04, 6'h03, 6'h3E};
  fdpin_top #(.STEP_CYC(STEP), .WR_CYC(WR)) u_fdpin_top (.clk_sys(clk_sys), .rst_b(rst_b),
    .motor_a_req(motor_a_req), .motor_b_req(motor_b_req), .sel_a_req(sel_a_req),
    .sel_b_req(sel_b_req), .step_req(step_req), .step_outward(step_outward),
    .side1_req(side1_req), .density_code(density_code), .write_active(write_active),
    .write_bit(write_bit), .cfg_wr(cfg_wr), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .index_n(index_n), .track_zero_n(track_zero_n), .write_prot_n(write_prot_n),
    .read_data_n(read_data_n), .media_changed_n(media_changed_n),
    .motor_a_on_oe(motor_a_on_oe), .motor_b_on_oe(motor_b_on_oe), .select_a_oe(select_a_oe),
    .select_b_oe(select_b_oe), .step_dir_oe(step_dir_oe), .step_oe(step_oe),
    .side_sel_oe(side_sel_oe), .density_select_bit0_oe(density_select_bit0_oe),
    .wr_serial_oe(wr_serial_oe), .wr_gate_oe(wr_gate_oe), .step_busy(step_busy),
    .input_pullup_disable(input_pullup_disable), .index_seen(index_seen),
    .track_zero(track_zero), .write_prot(write_prot), .read_pulse(read_pulse),
    .media_changed(media_changed));
  fdpin_drive_model u_fdpin_drive_model (.clk_sys(clk_sys), .step_pin(!step_oe),
    .dir_pin(!step_dir_oe), .prot(prot), .inserted(inserted), .index_n(index_n),
    .track_zero_n(track_zero_n), .write_prot_n(write_prot_n), .read_data_n(read_data_n),
    .media_changed_n(media_changed_n), .track(track));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // pulse counters and hang guard; pulse widths are measured, not assumed
  // sampled on the falling edge, clear of the edge that launches the outputs
  always @(negedge clk_sys) begin
    st_hi += step_oe;
    st_n += step_oe && !st_q;
    st_q = step_oe;
    wr_hi += wr_serial_oe;
    wr_n += wr_serial_oe && !wr_q;
    wr_q = wr_serial_oe;
    idx_n += index_seen;
    rd_n += read_pulse;
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clr;
    #1;
    st_n = 0; st_hi = 0; wr_n = 0; wr_hi = 0; idx_n = 0; rd_n = 0;
  endtask
  // one step request held for hold cycles; extra cycles land while busy
  task automatic do_step(input logic outw, input int hold, input int trk);
    clr();
    @(posedge clk_sys);
    step_outward <= outw;
    step_req <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    step_req <= 1'b0;
    #1;
    chk("step busy", step_busy, 1);
    repeat (10) @(posedge clk_sys);
    #1;
    chk("step count", st_n, 1);
    chk("step width", st_hi, STEP);
    chk("step idle", step_busy, 0);
    chk("track", track, trk);
  endtask
  task automatic do_wr(input logic p, input int n);
    @(posedge clk_sys);
    prot <= p;
    write_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    write_bit <= 1'b1;
    clr();
    @(posedge clk_sys);
    write_bit <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("gate", wr_gate_oe, !p);
    chk("write_prot", write_prot, p);
    repeat (6) @(posedge clk_sys);
    chk("wr count", wr_n, n);
    chk("wr width", wr_hi, n * WR);
    write_active <= 1'b0;
  endtask
  task automatic cfg(input logic [7:0] idx, input logic [7:0] d, input logic e);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_index <= idx;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
    chk("pullup_dis", input_pullup_disable, e);
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_b, motor_a_req, motor_b_req, sel_a_req, sel_b_req, step_req, step_outward} = '0;
    {side1_req, density_code, write_active, write_bit, cfg_wr, prot, inserted} = '0;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    // motor, select, step and write pins released while held in reset and just after
    repeat (4) @(posedge clk_sys);
    #1;
    chk("oe in reset", {motor_a_on_oe, select_a_oe, step_oe, wr_gate_oe}, 0);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("oe after reset", {motor_b_on_oe, select_b_oe, wr_serial_oe}, 0);
    $display("test reset done");
    // level pins from the row table
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      {motor_a_req, motor_b_req, sel_a_req, sel_b_req, side1_req, density_code} <= rin[i];
      @(posedge clk_sys);
      #1;
      chk("levels", {motor_a_on_oe, motor_b_on_oe, select_a_oe, select_b_oe,
        side_sel_oe, density_select_bit0_oe}, rexp[i]);
    end
    $display("test levels done");
    do_step(1'b0, 1, 3);
    do_step(1'b1, 1, 2);
    do_step(1'b1, 2, 1);
    do_step(1'b1, 1, 0);
    chk("track_zero", track_zero, 1);
    $display("test step done");
    do_wr(1'b0, 1);
    do_wr(1'b1, 0);
    $display("test write done");
    cfg(8'hF0, 8'h80, 1'b1);
    cfg(8'hF1, 8'h00, 1'b1);
    cfg(8'hF0, 8'h7F, 1'b0);
    $display("test config done");
    chk("media_changed", media_changed, 1);
    @(posedge clk_sys);
    inserted <= 1'b1;
    clr();
    repeat (40) @(posedge clk_sys);
    #1;
    chk("media_changed", media_changed, 0);
    chk("index count", idx_n, 2);
    chk("read count", rd_n, 5);
    $display("test status done");
    close_out();
  end
endmodule
